// ==== verilog/pafc_core.sv ====
// Period-averaging frequency counter, phase timer and input routing with AHB-Lite registers
//
// Chosen here: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`include "pafc_map.svh"
// Functional notes
// [RULE1] First signal zero crossing opens gate; time-base pulses accumulate while open.
// [RULE2] Later crossings keep the gate open while the interval has not elapsed.
// [RULE3] A second counter counts signal cycles completed while gating.
// [RULE4] After the interval is reached, gate closes only at next crossing.
// [RULE5] Average period is pulses divided by cycles; frequency is its reciprocal.
// [RULE6] Phase timer measures reference period and inter-channel crossing delay.
// [RULE7] Delay measured at rising and falling crossings, then averaged.
// [RULE8] Multiplexer routes channel A or B to level, frequency, reading paths.
// [RULE9] Outside two-channel functions all three paths take the selected channel.
// [RULE10] In two-channel functions reading takes selected, level and frequency other.
// [RULE11] Each channel picks front input or own generator monitor; aux on A only.
// [RULE12] Each channel terminates with 600 ohm, 150 ohm, or nothing.
// [RULE13] Autorange picks most sensitive unclipped range; fixed range overrides.
// [RULE14] Front end delivers synchronous rising and falling crossing pulses.
// [RULE15] Interval is a cycle count; done flag raised once results are valid.

module pafc_core #(
  parameter int CW     = 32,
  parameter int NW     = 16,
  parameter int NRANGE = 8
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        zc_a_rise,
  input  wire logic        zc_a_fall,
  input  wire logic        zc_b_rise,
  input  wire logic        zc_b_fall,
  input  wire logic        clip_a,
  input  wire logic        low_a,
  input  wire logic        clip_b,
  input  wire logic        low_b,
  output logic             level_src_b_q,
  output logic             freq_src_b_q,
  output logic             read_src_b_q,
  output logic             src_a_gen_q,
  output logic             src_a_aux_q,
  output logic             src_b_gen_q,
  output logic             term_a_600_q,
  output logic             term_a_150_q,
  output logic             term_b_600_q,
  output logic             term_b_150_q,
  output logic      [2:0]  range_a_q,
  output logic      [2:0]  range_b_q
);
  localparam int DW = 48;

  generate
    if (CW > 32 || CW + NW > DW || NW < 2 || NRANGE > 8) begin : g_chk
      $error("pafc_core: widths exceed the divider or register word");
    end
  endgenerate

  // Bus side
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic [31:0] hrdata_q;
  logic        addr_ok;
  logic [31:0] rdata;

  // Control registers
  logic        chan_sel_q;
  logic        two_ch_q;
  logic        ref_b_q;
  logic [31:0] interval_q;
  logic [31:0] input_q;
  logic        done_q;
  logic        ph_done_q;

  // Frequency counter
  pafc_pkg::pafc_fc_state_e state_q;
  logic [CW-1:0] pulses_q;
  logic [NW-1:0] cycles_q;
  logic [31:0]   avg_per_q;
  logic [31:0]   freq_q;
  logic          fc_zc;
  logic          reached;
  logic          start_wr;
  logic          abort_wr;
  logic          done_set;
  logic          done_clr;

  // Divider
  logic          div_start_q;
  logic [5:0]    div_cnt_q;
  logic [DW-1:0] quo_q;
  logic [32:0]   rem_q;
  logic [31:0]   den_q;
  logic [32:0]   rem_sh;
  logic          div_busy;

  // Phase timer
  logic        ref_rise;
  logic        ref_fall;
  logic        sel_rise;
  logic        sel_fall;
  logic [31:0] ref_cnt_q;
  logic [31:0] fall_cnt_q;
  logic [31:0] ref_per_q;
  logic [31:0] rise_dly_q;
  logic        rise_ok_q;
  logic        ref_seen_q;
  logic        fall_seen_q;
  logic [31:0] ph_dly_q;
  logic        ph_upd;
  logic [32:0] ph_sum;

  assign addr_ok  = hsel && htrans[1] && hready;
  assign start_wr = wr_pend_q && wr_addr_q == `PAFC_OFF_CTRL && hwdata[`PAFC_CTRL_START];
  assign abort_wr = wr_pend_q && wr_addr_q == `PAFC_OFF_CTRL && hwdata[`PAFC_CTRL_ABORT];

  // Zero wait states: reads are decoded in the address phase so the data
  // phase answers from a flop. A read issued in the same cycle as a
  // pending write's data phase would see the old value.
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (haddr[7:0])
      `PAFC_OFF_CTRL: begin
        rdata[`PAFC_CTRL_CHSEL] = chan_sel_q;
        rdata[`PAFC_CTRL_TWOCH] = two_ch_q;
        rdata[`PAFC_CTRL_REFB]  = ref_b_q;
      end
      `PAFC_OFF_INTERVAL: rdata = interval_q;
      `PAFC_OFF_INPUT:    rdata = input_q;
      `PAFC_OFF_STATUS: begin
        rdata[`PAFC_ST_DONE]   = done_q;
        rdata[`PAFC_ST_BUSY]   = state_q != pafc_pkg::FC_IDLE;
        rdata[`PAFC_ST_PHDONE] = ph_done_q;
        rdata[`PAFC_ST_RNGA_LSB +: 3] = range_a_q;
        rdata[`PAFC_ST_RNGB_LSB +: 3] = range_b_q;
      end
      `PAFC_OFF_PULSES: rdata = 32'(pulses_q);
      `PAFC_OFF_CYCLES: rdata = 32'(cycles_q);
      `PAFC_OFF_AVGPER: rdata = avg_per_q;
      `PAFC_OFF_FREQ:   rdata = freq_q;
      `PAFC_OFF_REFPER: rdata = ref_per_q;
      `PAFC_OFF_PHDLY:  rdata = ph_dly_q;
      default:          rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q  <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_q <= addr_ok && hwrite && haddr[31:8] == 24'h00_0000;
      wr_addr_q <= haddr[7:0];
      if (addr_ok && !hwrite) hrdata_q <= rdata;
    end
  end
  assign hrdata = hrdata_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan_sel_q <= 1'b0;
      two_ch_q   <= 1'b0;
      ref_b_q    <= 1'b0;
      interval_q <= `PAFC_INTERVAL_RST;
      input_q    <= `PAFC_INPUT_RST;
    end else if (wr_pend_q) begin
      if (wr_addr_q == `PAFC_OFF_CTRL) begin
        chan_sel_q <= hwdata[`PAFC_CTRL_CHSEL];
        two_ch_q   <= hwdata[`PAFC_CTRL_TWOCH];
        ref_b_q    <= hwdata[`PAFC_CTRL_REFB];
      end
      if (wr_addr_q == `PAFC_OFF_INTERVAL) interval_q <= hwdata; // RULE15
      if (wr_addr_q == `PAFC_OFF_INPUT)    input_q    <= hwdata;
    end
  end

  // Path routing and front-end switching
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level_src_b_q <= 1'b0;
      freq_src_b_q  <= 1'b0;
      read_src_b_q  <= 1'b0;
      src_a_gen_q   <= 1'b0;
      src_a_aux_q   <= 1'b0;
      src_b_gen_q   <= 1'b0;
      term_a_600_q  <= 1'b0;
      term_a_150_q  <= 1'b0;
      term_b_600_q  <= 1'b0;
      term_b_150_q  <= 1'b0;
    end else begin
      read_src_b_q  <= chan_sel_q; // RULE8
      level_src_b_q <= chan_sel_q ^ two_ch_q; // RULE9 RULE10
      freq_src_b_q  <= chan_sel_q ^ two_ch_q; // RULE9 RULE10
      src_a_gen_q   <= input_q[`PAFC_IN_SRCA_LSB +: 2] == pafc_pkg::SRC_GEN; // RULE11
      src_a_aux_q   <= input_q[`PAFC_IN_SRCA_LSB +: 2] == pafc_pkg::SRC_AUX; // RULE11
      src_b_gen_q   <= input_q[`PAFC_IN_SRCB]; // RULE11
      term_a_600_q  <= input_q[`PAFC_IN_TERMA_LSB +: 2] == pafc_pkg::TERM_600; // RULE12
      term_a_150_q  <= input_q[`PAFC_IN_TERMA_LSB +: 2] == pafc_pkg::TERM_150; // RULE12
      term_b_600_q  <= input_q[`PAFC_IN_TERMB_LSB +: 2] == pafc_pkg::TERM_600; // RULE12
      term_b_150_q  <= input_q[`PAFC_IN_TERMB_LSB +: 2] == pafc_pkg::TERM_150; // RULE12
    end
  end

  pafc_autorange #(.NRANGE(NRANGE), .RW(3)) u_range_a (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .auto_en     (input_q[`PAFC_IN_AUTOA]),
    .fixed_range (input_q[`PAFC_IN_FIXA_LSB +: 3]),
    .clip        (clip_a),
    .low         (low_a),
    .range_q     (range_a_q)
  );

  pafc_autorange #(.NRANGE(NRANGE), .RW(3)) u_range_b (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .auto_en     (input_q[`PAFC_IN_AUTOB]),
    .fixed_range (input_q[`PAFC_IN_FIXB_LSB +: 3]),
    .clip        (clip_b),
    .low         (low_b),
    .range_q     (range_b_q)
  );

  // Cycle boundaries are rising crossings of the frequency path channel
  assign fc_zc   = freq_src_b_q ? zc_b_rise : zc_a_rise; // RULE14
  assign reached = 32'(pulses_q) >= interval_q; // RULE15

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q     <= pafc_pkg::FC_IDLE;
      pulses_q    <= '0;
      cycles_q    <= '0;
      avg_per_q   <= 32'h0000_0000;
      freq_q      <= 32'h0000_0000;
      div_start_q <= 1'b0;
    end else begin
      div_start_q <= 1'b0;
      if (abort_wr) begin
        state_q <= pafc_pkg::FC_IDLE;
      end else begin
        unique case (state_q)
          pafc_pkg::FC_IDLE: begin
            if (start_wr) state_q <= pafc_pkg::FC_ARM;
          end
          pafc_pkg::FC_ARM: begin
            if (fc_zc) begin
              state_q  <= pafc_pkg::FC_OPEN; // RULE1
              pulses_q <= '0;
              cycles_q <= '0;
            end
          end
          pafc_pkg::FC_OPEN: begin
            pulses_q <= pulses_q + CW'(1); // RULE1
            if (fc_zc) begin
              cycles_q <= cycles_q + NW'(1); // RULE3
              if (reached) begin // RULE2
                state_q     <= pafc_pkg::FC_DIV1; // RULE4
                div_start_q <= 1'b1;
              end
            end
          end
          pafc_pkg::FC_DIV1: begin
            if (!div_start_q && !div_busy) begin
              avg_per_q   <= quo_q[31:0]; // RULE5
              state_q     <= pafc_pkg::FC_DIV2;
              div_start_q <= 1'b1;
            end
          end
          pafc_pkg::FC_DIV2: begin
            if (!div_start_q && !div_busy) begin
              freq_q  <= quo_q[31:0]; // RULE5
              state_q <= pafc_pkg::FC_IDLE;
            end
          end
          default: state_q <= pafc_pkg::FC_IDLE;
        endcase
      end
    end
  end

  // Shared restoring divider: first pulses/cycles, then
  // time-base rate times cycles over pulses, giving Hz directly.
  assign div_busy = div_cnt_q != 6'h00;
  assign rem_sh   = {rem_q[31:0], quo_q[DW-1]};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_q <= 6'h00;
      quo_q     <= '0;
      rem_q     <= '0;
      den_q     <= 32'h0000_0000;
    end else if (div_start_q) begin
      div_cnt_q <= 6'(DW);
      rem_q     <= '0;
      if (state_q == pafc_pkg::FC_DIV1) begin
        quo_q <= DW'(pulses_q); // RULE5
        den_q <= 32'(cycles_q);
      end else begin
        quo_q <= `PAFC_TB_HZ * DW'(cycles_q); // RULE5
        den_q <= 32'(pulses_q);
      end
    end else if (div_busy) begin
      div_cnt_q <= div_cnt_q - 6'h01;
      if (rem_sh >= {1'b0, den_q}) begin
        rem_q <= rem_sh - {1'b0, den_q};
        quo_q <= {quo_q[DW-2:0], 1'b1};
      end else begin
        rem_q <= rem_sh;
        quo_q <= {quo_q[DW-2:0], 1'b0};
      end
    end
  end

  // Done is sticky; a result landing in the clearing cycle still sets it
  assign done_set = state_q == pafc_pkg::FC_DIV2 && !div_start_q && !div_busy && !abort_wr;
  assign done_clr = wr_pend_q && wr_addr_q == `PAFC_OFF_STATUS && hwdata[`PAFC_ST_DONE];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_q <= 1'b0;
    end else if (done_set) begin
      done_q <= 1'b1; // RULE15
    end else if (done_clr) begin
      done_q <= 1'b0;
    end
  end

  // Phase timer: reference is one channel, the other is compared to it
  assign ref_rise = ref_b_q ? zc_b_rise : zc_a_rise;
  assign ref_fall = ref_b_q ? zc_b_fall : zc_a_fall;
  assign sel_rise = ref_b_q ? zc_a_rise : zc_b_rise;
  assign sel_fall = ref_b_q ? zc_a_fall : zc_b_fall;
  assign ph_upd   = sel_fall && fall_seen_q && rise_ok_q;
  assign ph_sum   = {1'b0, rise_dly_q} + {1'b0, fall_cnt_q + 32'h0000_0001};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_cnt_q   <= 32'h0000_0000;
      fall_cnt_q  <= 32'h0000_0000;
      ref_per_q   <= 32'h0000_0000;
      rise_dly_q  <= 32'h0000_0000;
      rise_ok_q   <= 1'b0;
      ref_seen_q  <= 1'b0;
      fall_seen_q <= 1'b0;
      ph_dly_q    <= 32'h0000_0000;
    end else begin
      ref_cnt_q  <= ref_rise ? 32'h0000_0000 : ref_cnt_q + 32'h0000_0001;
      fall_cnt_q <= ref_fall ? 32'h0000_0000 : fall_cnt_q + 32'h0000_0001;
      if (ref_rise) begin
        ref_seen_q <= 1'b1;
        if (ref_seen_q) ref_per_q <= ref_cnt_q + 32'h0000_0001; // RULE6
      end
      if (ref_fall) fall_seen_q <= 1'b1;
      if (sel_rise && ref_seen_q) begin
        rise_dly_q <= ref_cnt_q + 32'h0000_0001; // RULE6
        rise_ok_q  <= 1'b1;
      end
      if (ph_upd) begin
        ph_dly_q  <= ph_sum[32:1]; // RULE7
        rise_ok_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_done_q <= 1'b0;
    end else if (ph_upd) begin
      ph_done_q <= 1'b1;
    end else if (wr_pend_q && wr_addr_q == `PAFC_OFF_STATUS && hwdata[`PAFC_ST_PHDONE]) begin
      ph_done_q <= 1'b0;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence gate_closing_s;
    state_q == pafc_pkg::FC_OPEN && fc_zc && reached && !abort_wr ##1
      state_q == pafc_pkg::FC_DIV1;
  endsequence

  gate_opens_a: assert property (state_q == pafc_pkg::FC_ARM && fc_zc && !abort_wr |=> // RULE1
    state_q == pafc_pkg::FC_OPEN && pulses_q == '0 && cycles_q == '0)
    else $error("gate did not open on first crossing");
  pulse_accum_a: assert property (state_q == pafc_pkg::FC_OPEN && !abort_wr |=> // RULE1
    pulses_q == $past(pulses_q) + CW'(1)) else $error("pulses not accumulated");
  gate_held_a: assert property (state_q == pafc_pkg::FC_OPEN && !reached && !abort_wr |=> // RULE2
    state_q == pafc_pkg::FC_OPEN) else $error("gate closed before interval");
  cycle_count_a: assert property (state_q == pafc_pkg::FC_OPEN && fc_zc && !abort_wr |=> // RULE3
    cycles_q == $past(cycles_q) + NW'(1)) else $error("cycle not counted");
  no_midcycle_a: assert property (state_q == pafc_pkg::FC_OPEN && !fc_zc && !abort_wr |=> // RULE4
    state_q == pafc_pkg::FC_OPEN) else $error("gate closed between crossings");
  // Two 48-step divides plus their load and hand-over cycles
  result_ready_a: assert property (gate_closing_s |-> ##100 // RULE15
    done_q && state_q == pafc_pkg::FC_IDLE)
    else $error("result not ready in time");
  avg_period_a: assert property ($rose(done_q) |-> // RULE5
    DW'(avg_per_q) * DW'(cycles_q) <= DW'(pulses_q) &&
    DW'(pulses_q) < (DW'(avg_per_q) + DW'(1)) * DW'(cycles_q))
    else $error("average period wrong");
  phase_avg_a: assert property (ph_upd |=> // RULE7
    ph_dly_q == 32'((33'($past(rise_dly_q)) + 33'($past(fall_cnt_q)) + 33'(1)) >> 1))
    else $error("phase delay not averaged");
  routing_a: assert property (##1 read_src_b_q == $past(chan_sel_q) && // RULE8 RULE9 RULE10
    level_src_b_q == $past(chan_sel_q ^ two_ch_q) && freq_src_b_q == level_src_b_q)
    else $error("path routing wrong");
  term_excl_a: assert property (!(term_a_600_q && term_a_150_q) && // RULE12
    !(term_b_600_q && term_b_150_q)) else $error("two terminations at once");
  done_sticky_a: assert property (done_set |=> done_q) // RULE15
    else $error("done lost");
endmodule : pafc_core

// ==== pkg/pafc_map.svh ====
// Register map, field positions, reset values and timing counts of the counter core
`ifndef PAFC_MAP_SVH
`define PAFC_MAP_SVH

`define PAFC_OFF_CTRL      8'h00
`define PAFC_OFF_INTERVAL  8'h04
`define PAFC_OFF_INPUT     8'h08
`define PAFC_OFF_STATUS    8'h0C
`define PAFC_OFF_PULSES    8'h10
`define PAFC_OFF_CYCLES    8'h14
`define PAFC_OFF_AVGPER    8'h18
`define PAFC_OFF_FREQ      8'h1C
`define PAFC_OFF_REFPER    8'h20
`define PAFC_OFF_PHDLY     8'h24

`define PAFC_CTRL_START    0
`define PAFC_CTRL_CHSEL    1
`define PAFC_CTRL_TWOCH    2
`define PAFC_CTRL_REFB     3
`define PAFC_CTRL_ABORT    4

`define PAFC_IN_SRCA_LSB   0
`define PAFC_IN_SRCB       2
`define PAFC_IN_TERMA_LSB  4
`define PAFC_IN_TERMB_LSB  6
`define PAFC_IN_AUTOA      8
`define PAFC_IN_AUTOB      9
`define PAFC_IN_FIXA_LSB   12
`define PAFC_IN_FIXB_LSB   16

`define PAFC_ST_DONE       0
`define PAFC_ST_BUSY       1
`define PAFC_ST_PHDONE     2
`define PAFC_ST_RNGA_LSB   8
`define PAFC_ST_RNGB_LSB   12

`define PAFC_INTERVAL_RST  32'h0000_F424
`define PAFC_INPUT_RST     32'h0000_0300
`define PAFC_TB_HZ         48'h0000_05F5_E100
`define PAFC_CLK_MHZ       100
`define PAFC_AR_SETTLE_NS  1000
`define PAFC_AR_SETTLE_CYC ((`PAFC_AR_SETTLE_NS * `PAFC_CLK_MHZ) / 1000)

`endif

// ==== pkg/pafc_pkg.sv ====
// Types used by the counter core: gate states, termination and source codes
package pafc_pkg;
  typedef enum logic [2:0] {
    FC_IDLE = 3'b000,
    FC_ARM  = 3'b001,
    FC_OPEN = 3'b010,
    FC_DIV1 = 3'b011,
    FC_DIV2 = 3'b100
  } pafc_fc_state_e;

  typedef enum logic [1:0] {
    TERM_NONE = 2'b00,
    TERM_600  = 2'b01,
    TERM_150  = 2'b10
  } pafc_term_e;

  typedef enum logic [1:0] {
    SRC_FRONT = 2'b00,
    SRC_GEN   = 2'b01,
    SRC_AUX   = 2'b10
  } pafc_src_e;
endpackage : pafc_pkg

// ==== verilog/pafc_autorange.sv ====
// Per-channel peak-driven range selection with a user override
`timescale 1ns/1ps
`include "pafc_map.svh"

module pafc_autorange #(
  parameter int NRANGE = 8,
  parameter int RW     = 3
) (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          auto_en,
  input  wire logic [RW-1:0] fixed_range,
  input  wire logic          clip,
  input  wire logic          low,
  output logic      [RW-1:0] range_q
);
  localparam int SETTLE = (`PAFC_AR_SETTLE_CYC < 1) ? 1 : `PAFC_AR_SETTLE_CYC;
  localparam logic [RW-1:0] TOP = RW'(NRANGE - 1);

  generate
    if (NRANGE < 2 || NRANGE > (1 << RW)) begin : g_chk
      $error("pafc_autorange: NRANGE does not fit RW");
    end
  endgenerate

  logic [15:0] low_cnt_q;

  // Higher index is more sensitive; clipping steps back at once,
  // a quiet signal must stay quiet for the settle time before stepping up.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      range_q   <= '0;
      low_cnt_q <= '0;
    end else if (!auto_en) begin
      range_q   <= (fixed_range > TOP) ? TOP : fixed_range; // RULE13
      low_cnt_q <= '0;
    end else if (clip) begin
      low_cnt_q <= '0;
      if (range_q != '0) range_q <= range_q - RW'(1); // RULE13
    end else if (low && range_q != TOP) begin
      if (low_cnt_q == 16'(SETTLE - 1)) begin
        range_q   <= range_q + RW'(1); // RULE13
        low_cnt_q <= '0;
      end else begin
        low_cnt_q <= low_cnt_q + 16'h0001;
      end
    end else begin
      low_cnt_q <= '0;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  clip_backoff_a: assert property (auto_en && clip && range_q != '0 |=> // RULE13
    range_q == $past(range_q) - RW'(1)) else $error("clip did not lower range");
  fixed_override_a: assert property (!auto_en ##1 !auto_en |-> // RULE13
    range_q == (($past(fixed_range) > TOP) ? TOP : $past(fixed_range)))
    else $error("fixed range not applied");
endmodule : pafc_autorange

// ==== sim/pafc_zc_model.sv ====
// Zero-crossing comparator pair model that feeds the counter core
`timescale 1ns/1ps

module pafc_zc_model (
  input  wire logic hclk,
  input  wire logic run,
  input  wire logic [31:0] half,
  input  wire logic [31:0] dly,
  output logic      zc_a_rise,
  output logic      zc_a_fall,
  output logic      zc_b_rise,
  output logic      zc_b_fall
);
  int ph = 0;

  initial begin
    zc_a_rise = 1'b0;
    zc_a_fall = 1'b0;
    zc_b_rise = 1'b0;
    zc_b_fall = 1'b0;
  end

  // One-cycle pulses on hclk; B lags A by dly cycles so the phase delay is known
  always @(posedge hclk) begin
    ph        <= run ? (ph + 1) % (2 * half) : 0;
    zc_a_rise <= run && ph == 0;
    zc_a_fall <= run && ph == half;
    zc_b_rise <= run && ph == dly;
    zc_b_fall <= run && ph == half + dly;
  end
endmodule : pafc_zc_model

// ==== sim/tb_period_avg_freq_phase_counter.sv ====
// Self-checking bench for the counter core over AHB-Lite
`timescale 1ns/1ps
`include "pafc_map.svh"

module tb_period_avg_freq_phase_counter;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        clip_a = 1'b0, low_a = 1'b0, clip_b = 1'b0, low_b = 1'b0;
  logic        run = 1'b0;
  wire  logic [31:0] hrdata;
  wire  logic  hreadyout, hresp, za_r, za_f, zb_r, zb_f, lvl_b, frq_b, rd_b;
  wire  logic  a_gen, a_aux, b_gen, a600, a150, b600, b150;
  wire  logic [2:0] range_a_q, range_b_q;
  int          err_count = 0, compares = 0, cyc = 0;

  always #5 hclk = ~hclk;

  pafc_zc_model i_pafc_zc_model (.hclk(hclk), .run(run), .half(10), .dly(3),
    .zc_a_rise(za_r), .zc_a_fall(za_f), .zc_b_rise(zb_r), .zc_b_fall(zb_f));

  pafc_core i_pafc_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .zc_a_rise(za_r),
    .zc_a_fall(za_f), .zc_b_rise(zb_r), .zc_b_fall(zb_f), .clip_a(clip_a), .low_a(low_a),
    .clip_b(clip_b), .low_b(low_b), .level_src_b_q(lvl_b), .freq_src_b_q(frq_b),
    .read_src_b_q(rd_b), .src_a_gen_q(a_gen), .src_a_aux_q(a_aux), .src_b_gen_q(b_gen),
    .term_a_600_q(a600), .term_a_150_q(a150), .term_b_600_q(b600),
    .term_b_150_q(b150), .range_a_q(range_a_q), .range_b_q(range_b_q));

  task print_verdict;
    if (err_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  // Bounds every wait, including bus handshakes that never complete
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      $display("MISMATCH %0t run did not complete", $time);
      print_verdict();
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task ahb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(a, 1'b1, d, r);
  endtask : wr

  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    ahb(a, 1'b0, 32'h0, r);
    chk(r, exp);
  endtask : rdchk

  task wait_st(input int b);
    logic [31:0] v;
    int          n;
    v = 32'h0;
    n = 0;
    while (v[b] !== 1'b1 && n < 600) begin
      ahb(`PAFC_OFF_STATUS, 1'b0, 32'h0, v);
      n++;
    end
    chk({31'h0, v[b]}, 32'h1);
  endtask : wait_st

  task t_reset;
    rdchk(`PAFC_OFF_INTERVAL, `PAFC_INTERVAL_RST);
    rdchk(`PAFC_OFF_INPUT, `PAFC_INPUT_RST);
    rdchk(8'h40, 32'h0);
  endtask : t_reset

  task t_routing;
    for (int i = 0; i < 4; i++) begin
      wr(`PAFC_OFF_CTRL, i << 1);
      repeat (2) @(posedge hclk);
      chk({lvl_b, frq_b, rd_b}, {i[0] ^ i[1], i[0] ^ i[1], i[0]});
    end
  endtask : t_routing

  // Source codes front, gen, aux on A; terminations 600, 150 and unused code 3 on A, every termination code on B
  task t_input;
    for (int i = 0; i < 3; i++) begin
      wr(`PAFC_OFF_INPUT, 32'h300 | i | (i[0] << 2) | ((i + 1) << 4) | (((i + 2) % 3) << 6));
      repeat (2) @(posedge hclk);
      chk({a_gen, a_aux, b_gen}, {i == 1, i == 2, i[0]});
      chk({a600, a150, b600, b150}, {i == 0, i == 1, i == 2, i == 0});
    end
  endtask : t_input

  task t_range;
    wr(`PAFC_OFF_INPUT, 32'h0003_5000);
    repeat (3) @(posedge hclk);
    chk({range_a_q, range_b_q}, {3'h5, 3'h3});
    rdchk(`PAFC_OFF_STATUS, 32'h0000_3500);
    wr(`PAFC_OFF_INPUT, 32'h0000_0300);
    clip_a <= 1'b1;
    clip_b <= 1'b1;
    repeat (12) @(posedge hclk);
    chk({range_a_q, range_b_q}, 6'h0);
    clip_a <= 1'b0;
    clip_b <= 1'b0;
    low_a  <= 1'b1;
    repeat (150) @(posedge hclk);
    chk({range_a_q, range_b_q}, {3'h1, 3'h0});
    low_a  <= 1'b0;
  endtask : t_range

  // Period 20 cycles against an interval of 50: gate must close on the third crossing after it opens
  task t_freq;
    wr(`PAFC_OFF_INTERVAL, 32'd50);
    wr(`PAFC_OFF_STATUS, 32'h5);
    wr(`PAFC_OFF_CTRL, 32'h1);
    wait_st(`PAFC_ST_DONE);
    rdchk(`PAFC_OFF_PULSES, 32'd60);
    rdchk(`PAFC_OFF_CYCLES, 32'd3);
    rdchk(`PAFC_OFF_AVGPER, 32'd20);
    rdchk(`PAFC_OFF_FREQ, 32'd5000000);
  endtask : t_freq

  task t_phase;
    wr(`PAFC_OFF_CTRL, 32'h2);
    wr(`PAFC_OFF_STATUS, 32'h5);
    wait_st(`PAFC_ST_PHDONE);
    rdchk(`PAFC_OFF_REFPER, 32'd20);
    rdchk(`PAFC_OFF_PHDLY, 32'd3);
    // Reference on B: A then trails it by 17; wait out results mixing both references
    wr(`PAFC_OFF_CTRL, 32'hA);
    repeat (45) @(posedge hclk);
    wr(`PAFC_OFF_STATUS, 32'h4);
    wait_st(`PAFC_ST_PHDONE);
    rdchk(`PAFC_OFF_REFPER, 32'd20);
    rdchk(`PAFC_OFF_PHDLY, 32'd17);
  endtask : t_phase

  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    t_reset();
    t_routing();
    t_input();
    t_range();
    run <= 1'b1;
    t_freq();
    t_phase();
    print_verdict();
  end
endmodule : tb_period_avg_freq_phase_counter
